// [hw/tlb_maint.sv]
// Purpose: translation buffers, invalidate, sync hold and table search
// Assumes: all inputs synchronous to SYS_CLK_IN, CE_IN freezes state
// Notes:   lookup answers are registered, one cycle after the request
// How it works
// - invalidate clears both ways, both buffers
// - invalidations never broadcast, remote ones ignored
// - sync with hold asserted stops execution
// - hold negated lets execution resume after sync
// - invalidate-all opcode raises illegal instruction
// - zeroing write-through or inhibited page faults alignment
// - entry reads use attribute 001, cacheable burst
// - primary match: H clear, valid, ids equal
// - page number is segment id plus index
// - try eight primary entries, then secondary group
// - secondary match: H set, valid, ids equal
// - match loads buffer, then sets referenced bit
// - changed bit only without protection violation
// - no secondary match gives storage fault
// - search reads global, non-exclusive, cacheable
// - referenced bit may precede alignment or violation
// - three miss kinds: fetch, load, store
// - index bits select a two-entry set
// - store to clean page counts as store miss
`timescale 1ns/1ps
module tlb_maint (
  input  wire logic        SYS_CLK_IN,
  input  wire logic        RST_IN,
  input  wire logic        CE_IN,
  input  wire logic        I_REQ_IN,
  input  wire logic [31:0] I_EA_IN,
  input  wire logic [23:0] I_SEGMENT_IDENTIFIER_IN,
  output logic             I_HIT_OUT,
  output logic             I_MISS_OUT,
  input  wire logic        D_REQ_IN,
  input  wire logic [31:0] D_EA_IN,
  input  wire logic [23:0] D_SEGMENT_IDENTIFIER_IN,
  input  wire logic        D_STORE_IN,
  input  wire logic        D_ZERO_IN,
  output logic             D_HIT_OUT,
  output logic             D_MISS_LOAD_OUT,
  output logic             D_MISS_STORE_OUT,
  output logic             ALIGN_FAULT_OUT,
  input  wire logic        INVAL_IN,
  input  wire logic [31:0] INVAL_EA_IN,
  input  wire logic        INVAL_ALL_IN,
  output logic             ILLEGAL_OP_OUT,
  input  wire logic        SYNC_EXEC_IN,
  input  wire logic        SYNC_HOLD_IN,
  output logic             EXEC_STALL_OUT,
  output logic             SYNC_DONE_OUT,
  input  wire logic        SRCH_START_IN,
  input  wire logic        SRCH_INSTR_IN,
  input  wire logic        SRCH_STORE_IN,
  input  wire logic        SRCH_PROT_IN,
  input  wire logic [23:0] SRCH_SEGMENT_IDENTIFIER_IN,
  input  wire logic [31:0] SRCH_EA_IN,
  input  wire logic [31:0] SRCH_PRI_BASE_IN,
  input  wire logic [31:0] SRCH_SEC_BASE_IN,
  output logic             SRCH_BUSY_OUT,
  output logic             SRCH_DONE_OUT,
  output logic             INSTR_STORAGE_FAULT_OUT,
  output logic             DATA_STORAGE_FAULT_OUT,
  output logic             MEM_REQ_OUT,
  output logic             MEM_WR_OUT,
  output logic [31:0]      MEM_ADDR_OUT,
  output logic [63:0]      MEM_WDATA_OUT,
  output logic [2:0]       MEM_ATTR_OUT,
  output logic             MEM_GLOBAL_OUT,
  output logic             MEM_EXCL_OUT,
  input  wire logic        MEM_ACK_IN,
  input  wire logic [63:0] MEM_RDATA_IN
);
  localparam int IW = $clog2(tlb_pkg::SETS);

  typedef struct packed {
    tlb_pkg::sync_state_t sync;
    logic sync_done, illegal;
    logic i_hit, i_miss;
    logic d_hit, d_miss_ld, d_miss_st, align;
  } top_t;
  top_t r_reg, r_next;

  tlb_pkg::tlb_entry_t iw0, iw1, dw0, dw1, new_ent, d_ent;
  logic wr_i, wr_d, i_kill, d_kill, i_h, d_h0, d_h1, d_wr;

  // set index taken from EA15-EA19; a flush steps it through all sets
  function automatic logic [IW-1:0] set_of(input logic [31:0] ea);
    set_of = ea[tlb_pkg::IDX_HI:tlb_pkg::IDX_LO];
  endfunction

  // valid entry whose segment id and both page index pieces agree
  function automatic logic tag_hit(input tlb_pkg::tlb_entry_t e, input logic [31:0] ea,
                                   input logic [23:0] segment_identifier);
    tag_hit = e.valid && e.segment_identifier == segment_identifier
      && e.abbreviated_page_index == ea[tlb_pkg::API_HI:tlb_pkg::API_LO]
      && e.pgx == ea[tlb_pkg::PGX_HI:tlb_pkg::PGX_LO];
  endfunction

  // invalidates come only from the local port; no snoop input exists
  tlb_array #(.SETS(tlb_pkg::SETS)) u_instr_translation_buffer (
    .clk_in       (SYS_CLK_IN),
    .rst_in       (RST_IN),
    .ce_in        (CE_IN),
    .rd_set_in    (set_of(I_EA_IN)),
    .way0_out     (iw0),
    .way1_out     (iw1),
    .wr_in        (wr_i),
    .wr_set_in    (set_of(SRCH_EA_IN)),
    .wr_entry_in  (new_ent),
    .inval_in     (INVAL_IN),
    .inval_set_in (set_of(INVAL_EA_IN))
  );

  tlb_array #(.SETS(tlb_pkg::SETS)) u_data_translation_buffer (
    .clk_in       (SYS_CLK_IN),
    .rst_in       (RST_IN),
    .ce_in        (CE_IN),
    .rd_set_in    (set_of(D_EA_IN)),
    .way0_out     (dw0),
    .way1_out     (dw1),
    .wr_in        (wr_d),
    .wr_set_in    (set_of(SRCH_EA_IN)),
    .wr_entry_in  (new_ent),
    .inval_in     (INVAL_IN),
    .inval_set_in (set_of(INVAL_EA_IN))
  );

  // search address is held stable by the handler while busy
  pte_search u_search (
    .clk_in        (SYS_CLK_IN),
    .rst_in        (RST_IN),
    .ce_in         (CE_IN),
    .start_in      (SRCH_START_IN),
    .instr_in      (SRCH_INSTR_IN),
    .store_in      (SRCH_STORE_IN),
    .prot_in       (SRCH_PROT_IN),
    .segment_identifier_in       (SRCH_SEGMENT_IDENTIFIER_IN),
    .ea_in         (SRCH_EA_IN),
    .pri_base_in   (SRCH_PRI_BASE_IN),
    .sec_base_in   (SRCH_SEC_BASE_IN),
    .mem_req_out   (MEM_REQ_OUT),
    .mem_wr_out    (MEM_WR_OUT),
    .mem_addr_out  (MEM_ADDR_OUT),
    .mem_wdata_out (MEM_WDATA_OUT),
    .mem_ack_in    (MEM_ACK_IN),
    .mem_rdata_in  (MEM_RDATA_IN),
    .tlb_wr_i_out  (wr_i),
    .tlb_wr_d_out  (wr_d),
    .tlb_entry_out (new_ent),
    .busy_out      (SRCH_BUSY_OUT),
    .done_out      (SRCH_DONE_OUT),
    .ifault_out    (INSTR_STORAGE_FAULT_OUT),
    .dfault_out    (DATA_STORAGE_FAULT_OUT)
  );

  // search traffic is a cacheable, coherent, non-exclusive burst
  assign MEM_ATTR_OUT   = tlb_pkg::ATTR_PTE_READ;
  assign MEM_GLOBAL_OUT = 1'b1;
  assign MEM_EXCL_OUT   = 1'b0;

  // an invalidate in the lookup cycle hides the set at once
  assign i_kill = INVAL_IN && set_of(INVAL_EA_IN) == set_of(I_EA_IN);
  assign d_kill = INVAL_IN && set_of(INVAL_EA_IN) == set_of(D_EA_IN);
  assign i_h    = !i_kill && (tag_hit(iw0, I_EA_IN, I_SEGMENT_IDENTIFIER_IN) || tag_hit(iw1, I_EA_IN, I_SEGMENT_IDENTIFIER_IN));
  assign d_h0   = !d_kill && tag_hit(dw0, D_EA_IN, D_SEGMENT_IDENTIFIER_IN);
  assign d_h1   = !d_kill && tag_hit(dw1, D_EA_IN, D_SEGMENT_IDENTIFIER_IN);
  assign d_ent  = d_h0 ? dw0 : dw1;
  assign d_wr   = D_STORE_IN || D_ZERO_IN;

  // one exception per access; alignment is checked before the C bit
  always_comb begin
    r_next           = r_reg;
    r_next.sync_done = 1'b0;
    r_next.illegal   = INVAL_ALL_IN;
    r_next.i_hit     = I_REQ_IN && i_h;
    r_next.i_miss    = I_REQ_IN && !i_h;
    r_next.d_hit     = 1'b0;
    r_next.d_miss_ld = 1'b0;
    r_next.d_miss_st = 1'b0;
    r_next.align     = 1'b0;
    if (D_REQ_IN) begin
      if (!(d_h0 || d_h1)) begin
        r_next.d_miss_st = d_wr;
        r_next.d_miss_ld = !d_wr;
      end else if (D_ZERO_IN && (d_ent.wt || d_ent.ci)) begin
        r_next.align = 1'b1;
      end else if (d_wr && !d_ent.chg) begin
        r_next.d_miss_st = 1'b1;
      end else begin
        r_next.d_hit = 1'b1;
      end
    end
    unique case (r_reg.sync)
      tlb_pkg::SYNC_RUN: begin
        if (SYNC_EXEC_IN && SYNC_HOLD_IN) begin
          r_next.sync = tlb_pkg::SYNC_HOLD;
        end else if (SYNC_EXEC_IN) begin
          r_next.sync_done = 1'b1;
        end
      end
      tlb_pkg::SYNC_HOLD: begin
        if (!SYNC_HOLD_IN) begin
          r_next.sync      = tlb_pkg::SYNC_RUN;
          r_next.sync_done = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge SYS_CLK_IN) begin
    if (RST_IN) begin
      r_reg <= '0;
    end else if (CE_IN) begin
      r_reg <= r_next;
    end
  end

  // stall stays up for as long as outside logic keeps the hold
  assign EXEC_STALL_OUT   = r_reg.sync == tlb_pkg::SYNC_HOLD;
  assign SYNC_DONE_OUT    = r_reg.sync_done;
  assign ILLEGAL_OP_OUT   = r_reg.illegal;
  assign I_HIT_OUT        = r_reg.i_hit;
  assign I_MISS_OUT       = r_reg.i_miss;
  assign D_HIT_OUT        = r_reg.d_hit;
  assign D_MISS_LOAD_OUT  = r_reg.d_miss_ld;
  assign D_MISS_STORE_OUT = r_reg.d_miss_st;
  assign ALIGN_FAULT_OUT  = r_reg.align;

  default clocking cb @(posedge SYS_CLK_IN);
  endclocking
  default disable iff (RST_IN);

  a_sync_stall: assert property (SYNC_EXEC_IN && SYNC_HOLD_IN && CE_IN && !EXEC_STALL_OUT
    |=> EXEC_STALL_OUT && !SYNC_DONE_OUT)
    else $error("sync with hold did not stall");
  a_sync_release: assert property (EXEC_STALL_OUT && !SYNC_HOLD_IN && CE_IN
    |=> !EXEC_STALL_OUT && SYNC_DONE_OUT)
    else $error("stall not released after hold drop");
  a_illegal_op: assert property (INVAL_ALL_IN && CE_IN |=> ILLEGAL_OP_OUT)
    else $error("invalidate-all opcode not refused");
  a_align_zero: assert property (ALIGN_FAULT_OUT |-> !D_HIT_OUT && !D_MISS_STORE_OUT && $past(D_ZERO_IN))
    else $error("alignment fault without zeroing access");
  a_mem_attr: assert property (MEM_REQ_OUT |-> MEM_ATTR_OUT == 3'h1 && MEM_GLOBAL_OUT && !MEM_EXCL_OUT)
    else $error("search access attributes wrong");
  a_miss_split: assert property (D_REQ_IN && CE_IN && !(d_h0 || d_h1)
    |=> D_MISS_STORE_OUT == $past(d_wr) && D_MISS_LOAD_OUT != $past(d_wr))
    else $error("data miss kind wrong");
  a_fault_split: assert property (!(INSTR_STORAGE_FAULT_OUT && DATA_STORAGE_FAULT_OUT))
    else $error("both storage faults at once");
  a_stale_hit: assert property (INVAL_IN && D_REQ_IN && CE_IN && d_kill |=> !D_HIT_OUT)
    else $error("lookup hit an invalidated set");
  a_clean_store: assert property (D_REQ_IN && CE_IN && d_wr && !D_ZERO_IN && d_h0 && !dw0.chg
    |=> D_MISS_STORE_OUT)
    else $error("store to clean page not trapped");

  c_sync_hold: cover property (EXEC_STALL_OUT [*3] ##1 SYNC_DONE_OUT);
  c_srch_done: cover property (SRCH_DONE_OUT);
  c_srch_fault: cover property (INSTR_STORAGE_FAULT_OUT || DATA_STORAGE_FAULT_OUT);
  c_align: cover property (ALIGN_FAULT_OUT);
endmodule

// [hw/tlb_pkg.sv]
// Purpose: shared constants and types for translation-buffer upkeep
// Assumes: EA0 is bit 31 of an address, entry word 0 is bits 63:32
// Notes:   page table entries are read and written as 64-bit words
package tlb_pkg;
  localparam int SETS      = 32;
  localparam int GROUP_LEN = 8;
  localparam int PTE_BYTES = 8;
  localparam int IDX_LO    = 12; // set index, EA15-EA19
  localparam int IDX_HI    = 16;
  localparam int PGX_LO    = 17; // extra page index, EA10-EA14
  localparam int PGX_HI    = 21;
  localparam int API_LO    = 22; // abbreviated page index, EA4-EA9
  localparam int API_HI    = 27;
  localparam int PTE_V     = 63;
  localparam int SEGMENT_IDENTIFIER_HI   = 62;
  localparam int SEGMENT_IDENTIFIER_LO   = 39;
  localparam int PTE_H     = 38;
  localparam int PAPI_HI   = 37;
  localparam int PAPI_LO   = 32;
  localparam int PTE_R     = 8;
  localparam int PTE_C     = 7;
  localparam int PTE_W     = 6;
  localparam int PTE_I     = 5;
  localparam logic [2:0] ATTR_PTE_READ = 3'h1;

  typedef struct packed {
    logic        valid;
    logic [23:0] segment_identifier;
    logic [5:0]  abbreviated_page_index;
    logic [4:0]  pgx;
    logic        chg;
    logic        wt;
    logic        ci;
  } tlb_entry_t;

  typedef enum logic {SYNC_RUN, SYNC_HOLD} sync_state_t;
  typedef enum logic [2:0] {SRCH_IDLE, SRCH_READ, SRCH_LOAD, SRCH_WREF, SRCH_WCHG} search_state_t;
endpackage

// [hw/tlb_array.sv]
// Purpose: one two-way translation buffer with set invalidate
// Assumes: reads are combinational from the flop array
// Notes:   valid bits survive reset; software flushes before use
`timescale 1ns/1ps
module tlb_array #(
  parameter int SETS = tlb_pkg::SETS,
  parameter int IW   = $clog2(SETS)
) (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire logic                ce_in,
  input  wire logic [IW-1:0]       rd_set_in,
  output tlb_pkg::tlb_entry_t      way0_out,
  output tlb_pkg::tlb_entry_t      way1_out,
  input  wire logic                wr_in,
  input  wire logic [IW-1:0]       wr_set_in,
  input  wire tlb_pkg::tlb_entry_t wr_entry_in,
  input  wire logic                inval_in,
  input  wire logic [IW-1:0]       inval_set_in
);
  tlb_pkg::tlb_entry_t mem_reg [SETS][2];
  logic [SETS-1:0]     repl_reg;
  logic                wr_way;

  assign way0_out = mem_reg[rd_set_in][0];
  assign way1_out = mem_reg[rd_set_in][1];

  // fill an empty way first, else the way not written last time
  always_comb begin
    if (!mem_reg[wr_set_in][0].valid) begin
      wr_way = 1'b0;
    end else if (!mem_reg[wr_set_in][1].valid) begin
      wr_way = 1'b1;
    end else begin
      wr_way = repl_reg[wr_set_in];
    end
  end

  // invalidate comes last so it wins over a load to the same set
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      repl_reg <= '0;
    end else if (ce_in) begin
      if (wr_in) begin
        mem_reg[wr_set_in][wr_way] <= wr_entry_in;
        repl_reg[wr_set_in]        <= !wr_way;
      end
      if (inval_in) begin
        mem_reg[inval_set_in][0].valid <= 1'b0;
        mem_reg[inval_set_in][1].valid <= 1'b0;
      end
    end
  end

  a_inval_both: assert property (@(posedge clk_in) disable iff (rst_in)
    inval_in && ce_in |=> !mem_reg[$past(inval_set_in)][0].valid && !mem_reg[$past(inval_set_in)][1].valid)
    else $error("set not cleared in both ways");
endmodule

// [hw/pte_search.sv]
// Purpose: primary then secondary entry-group search in memory
// Assumes: memory holds req until it answers with a one-cycle ack
// Notes:   reference bit is written even on a protection violation
`timescale 1ns/1ps
module pte_search (
  input  wire logic                clk_in,
  input  wire logic                rst_in,
  input  wire logic                ce_in,
  input  wire logic                start_in,
  input  wire logic                instr_in,
  input  wire logic                store_in,
  input  wire logic                prot_in,
  input  wire logic [23:0]         segment_identifier_in,
  input  wire logic [31:0]         ea_in,
  input  wire logic [31:0]         pri_base_in,
  input  wire logic [31:0]         sec_base_in,
  output logic                     mem_req_out,
  output logic                     mem_wr_out,
  output logic [31:0]              mem_addr_out,
  output logic [63:0]              mem_wdata_out,
  input  wire logic                mem_ack_in,
  input  wire logic [63:0]         mem_rdata_in,
  output logic                     tlb_wr_i_out,
  output logic                     tlb_wr_d_out,
  output tlb_pkg::tlb_entry_t      tlb_entry_out,
  output logic                     busy_out,
  output logic                     done_out,
  output logic                     ifault_out,
  output logic                     dfault_out
);
  typedef struct packed {
    tlb_pkg::search_state_t st;
    logic        sec, instr, store, prot;
    logic [2:0]  idx;
    logic [23:0] segment_identifier;
    logic [31:0] ea, sec_base, addr;
    logic [63:0] pte;
    logic        req, wr, done, ifault, dfault;
  } srch_t;
  srch_t r_reg, r_next;
  logic  hit, need_c;

  // match on the virtual page number: segment id joined with page index
  assign hit = mem_rdata_in[tlb_pkg::PTE_V] && (mem_rdata_in[tlb_pkg::PTE_H] == r_reg.sec)
    && ({mem_rdata_in[tlb_pkg::SEGMENT_IDENTIFIER_HI:tlb_pkg::SEGMENT_IDENTIFIER_LO], mem_rdata_in[tlb_pkg::PAPI_HI:tlb_pkg::PAPI_LO]}
    == {r_reg.segment_identifier, r_reg.ea[tlb_pkg::API_HI:tlb_pkg::API_LO]});
  assign need_c = r_reg.store && !r_reg.prot && !r_reg.pte[tlb_pkg::PTE_C];

  // walk the group entry by entry; reads carry no write enable
  always_comb begin
    r_next        = r_reg;
    r_next.done   = 1'b0;
    r_next.ifault = 1'b0;
    r_next.dfault = 1'b0;
    unique case (r_reg.st)
      tlb_pkg::SRCH_IDLE: begin
        if (start_in) begin
          r_next          = '{st: tlb_pkg::SRCH_READ, instr: instr_in, store: store_in, prot: prot_in,
                              segment_identifier: segment_identifier_in, ea: ea_in, sec_base: sec_base_in, addr: pri_base_in,
                              req: 1'b1, default: '0};
        end
      end
      tlb_pkg::SRCH_READ: begin
        if (mem_ack_in) begin
          if (hit) begin
            r_next.req = 1'b0;
            r_next.pte = mem_rdata_in;
            r_next.st  = tlb_pkg::SRCH_LOAD;
          end else if (r_reg.idx == 3'(tlb_pkg::GROUP_LEN - 1)) begin
            if (r_reg.sec) begin
              r_next.req    = 1'b0;
              r_next.st     = tlb_pkg::SRCH_IDLE;
              r_next.ifault = r_reg.instr;
              r_next.dfault = !r_reg.instr;
            end else begin
              r_next.sec  = 1'b1;
              r_next.idx  = 3'h0;
              r_next.addr = r_reg.sec_base;
            end
          end else begin
            r_next.idx  = r_reg.idx + 3'h1;
            r_next.addr = r_reg.addr + 32'(tlb_pkg::PTE_BYTES);
          end
        end
      end
      tlb_pkg::SRCH_LOAD: begin
        r_next.pte[tlb_pkg::PTE_R] = 1'b1;
        r_next.req = 1'b1;
        r_next.wr  = 1'b1;
        r_next.st  = tlb_pkg::SRCH_WREF;
      end
      tlb_pkg::SRCH_WREF: begin
        if (mem_ack_in) begin
          r_next.req = need_c;
          r_next.pte[tlb_pkg::PTE_C] = r_reg.pte[tlb_pkg::PTE_C] | need_c;
          r_next.st   = need_c ? tlb_pkg::SRCH_WCHG : tlb_pkg::SRCH_IDLE;
          r_next.done = !need_c;
        end
      end
      tlb_pkg::SRCH_WCHG: begin
        if (mem_ack_in) begin
          r_next.req  = 1'b0;
          r_next.st   = tlb_pkg::SRCH_IDLE;
          r_next.done = 1'b1;
        end
      end
    endcase
    // skip the reference write when the bit is already set
    if (r_reg.st == tlb_pkg::SRCH_LOAD && r_reg.pte[tlb_pkg::PTE_R]) begin
      r_next.req  = need_c;
      r_next.wr   = need_c;
      r_next.pte[tlb_pkg::PTE_C] = r_reg.pte[tlb_pkg::PTE_C] | need_c;
      r_next.st   = need_c ? tlb_pkg::SRCH_WCHG : tlb_pkg::SRCH_IDLE;
      r_next.done = !need_c;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      r_reg <= '0;
    end else if (ce_in) begin
      r_reg <= r_next;
    end
  end

  assign mem_req_out   = r_reg.req;
  assign mem_wr_out    = r_reg.wr;
  assign mem_addr_out  = r_reg.addr;
  assign mem_wdata_out = r_reg.pte;
  // buffer load lands in the load cycle, so done never comes ahead of it
  assign tlb_wr_i_out  = r_reg.st == tlb_pkg::SRCH_LOAD && r_reg.instr;
  assign tlb_wr_d_out  = r_reg.st == tlb_pkg::SRCH_LOAD && !r_reg.instr;
  assign busy_out      = r_reg.st != tlb_pkg::SRCH_IDLE;
  assign done_out      = r_reg.done;
  assign ifault_out    = r_reg.ifault;
  assign dfault_out    = r_reg.dfault;
  // loaded entry already carries the changed bit that will be written
  assign tlb_entry_out = '{valid: 1'b1, segment_identifier: r_reg.pte[tlb_pkg::SEGMENT_IDENTIFIER_HI:tlb_pkg::SEGMENT_IDENTIFIER_LO],
                           abbreviated_page_index: r_reg.pte[tlb_pkg::PAPI_HI:tlb_pkg::PAPI_LO],
                           pgx: r_reg.ea[tlb_pkg::PGX_HI:tlb_pkg::PGX_LO],
                           chg: r_reg.pte[tlb_pkg::PTE_C] | need_c,
                           wt: r_reg.pte[tlb_pkg::PTE_W], ci: r_reg.pte[tlb_pkg::PTE_I]};

  a_chg_gate: assert property (@(posedge clk_in) disable iff (rst_in)
    r_reg.st == tlb_pkg::SRCH_WCHG |-> r_reg.store && !r_reg.prot && r_reg.wr)
    else $error("changed bit written without clean store");
endmodule

// [sim/pte_mem.sv]
// Purpose: page table memory answering entry reads and writes
// Assumes: request held until the one-cycle ack, one 64-bit entry each
// Notes:   idle read data toggles so stale data never looks like an answer
`timescale 1ns/1ps
module pte_mem (
  input  wire logic        clk_in,
  input  wire logic        req_in,
  input  wire logic        wr_in,
  input  wire logic [31:0] addr_in,
  input  wire logic [63:0] wdata_in,
  input  wire logic [3:0]  wait_in,
  output logic             ack_out,
  output logic [63:0]      rdata_out
);
  logic [63:0] pte [0:15];
  logic [3:0]  cnt;
  int          n_wr;
  wire  [3:0]  idx = {addr_in[13], addr_in[5:3]};
  initial begin
    ack_out = 1'b0;
    rdata_out = 64'h0;
    cnt = 4'h0;
    n_wr = 0;
  end
  // answer after wait_in idle cycles; skip the ack cycle so a new request is seen fresh
  always @(posedge clk_in) begin
    ack_out <= 1'b0;
    rdata_out <= ~rdata_out;
    if (req_in && !ack_out) begin
      if (cnt >= wait_in) begin
        cnt <= 4'h0;
        ack_out <= 1'b1;
        if (wr_in) begin
          pte[idx] <= wdata_in;
          n_wr <= n_wr + 1;
        end else begin
          rdata_out <= pte[idx];
        end
      end else begin
        cnt <= cnt + 4'h1;
      end
    end
  end
endmodule

// [sim/tlb_maint_tb_top.sv]
// Purpose: bench for invalidate, sync hold, lookups and table search
// Assumes: lookups answer one cycle after the request edge
// Notes:   all sets are flushed first, reset leaves valid bits unknown
`timescale 1ns/1ps
module tlb_maint_tb_top;
  localparam logic [23:0] VS = 24'hABCDE1;
  logic        clk, rst, ireq, dreq, dst, dz, inv, inva, sx, sh, ss, si, sst, sp, req, wr, ack;
  logic        stall, sdone, ill, busy, glob, excl, ce;
  logic [31:0] iea, dea, iv_ea, sea, addr;
  logic [63:0] wd, rd;
  logic [3:0]  slow, dout;
  logic [2:0]  sout, attr;
  logic [1:0]  iout;
  int          fail_count, n_checks, cyc, w0;

  tlb_maint DUT (.SYS_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .I_REQ_IN(ireq), .I_EA_IN(iea), .I_SEGMENT_IDENTIFIER_IN(VS),
    .I_HIT_OUT(iout[1]), .I_MISS_OUT(iout[0]), .D_REQ_IN(dreq), .D_EA_IN(dea), .D_SEGMENT_IDENTIFIER_IN(VS),
    .D_STORE_IN(dst), .D_ZERO_IN(dz), .D_HIT_OUT(dout[3]), .D_MISS_LOAD_OUT(dout[2]),
    .D_MISS_STORE_OUT(dout[1]), .ALIGN_FAULT_OUT(dout[0]), .INVAL_IN(inv), .INVAL_EA_IN(iv_ea),
    .INVAL_ALL_IN(inva), .ILLEGAL_OP_OUT(ill), .SYNC_EXEC_IN(sx), .SYNC_HOLD_IN(sh), .EXEC_STALL_OUT(stall),
    .SYNC_DONE_OUT(sdone), .SRCH_START_IN(ss), .SRCH_INSTR_IN(si), .SRCH_STORE_IN(sst), .SRCH_PROT_IN(sp),
    .SRCH_SEGMENT_IDENTIFIER_IN(VS), .SRCH_EA_IN(sea), .SRCH_PRI_BASE_IN(32'h00001000), .SRCH_SEC_BASE_IN(32'h00002000),
    .SRCH_BUSY_OUT(busy), .SRCH_DONE_OUT(sout[2]), .INSTR_STORAGE_FAULT_OUT(sout[1]),
    .DATA_STORAGE_FAULT_OUT(sout[0]), .MEM_REQ_OUT(req), .MEM_WR_OUT(wr), .MEM_ADDR_OUT(addr),
    .MEM_WDATA_OUT(wd), .MEM_ATTR_OUT(attr), .MEM_GLOBAL_OUT(glob), .MEM_EXCL_OUT(excl),
    .MEM_ACK_IN(ack), .MEM_RDATA_IN(rd));
  pte_mem mem (.clk_in(clk), .req_in(req), .wr_in(wr), .addr_in(addr), .wdata_in(wd), .wait_in(slow),
    .ack_out(ack), .rdata_out(rd));

  function automatic logic [63:0] mk(input logic v, h, input logic [23:0] vs, input logic [5:0] a,
                                     input logic r, c, w);
    mk = {v, vs, h, a, 23'h0, r, c, w, 6'h00};
  endfunction
  // set index s, page index a, extra index fixed at 3
  function automatic logic [31:0] ea(input logic [4:0] s, input logic [5:0] a);
    ea = {4'h0, a, 5'h03, s, 12'h000};
  endfunction
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic inval(input logic [4:0] s);
    iv_ea = {15'h0000, s, 12'h000};
    inv = 1'b1;
    tick();
    inv = 1'b0;
    tick();
  endtask
  task automatic ilook(input logic [31:0] a, input logic [1:0] exp);
    iea = a;
    ireq = 1'b1;
    tick();
    ireq = 1'b0;
    chk(iout, exp);
    tick();
  endtask
  // answer bits: hit, load miss, store miss, alignment
  task automatic dlook(input logic [31:0] a, input logic st, zr, input logic [3:0] exp);
    dea = a;
    dst = st;
    dz = zr;
    dreq = 1'b1;
    tick();
    dreq = 1'b0;
    chk(dout, exp);
    tick();
  endtask
  // every entry matches except for the group-select bit
  task automatic fill(input logic [5:0] a);
    for (int k = 0; k < 16; k++) mem.pte[k] = mk(1'b1, k < 8, VS, a, 1'b0, 1'b0, 1'b0);
    w0 = mem.n_wr;
  endtask
  // answer bits: done, fetch fault, data fault
  task automatic srch(input logic in, st, pr, input logic [31:0] a, input logic [2:0] exp);
    si = in;
    sst = st;
    sp = pr;
    sea = a;
    ss = 1'b1;
    tick();
    ss = 1'b0;
    for (int k = 0; k < 200 && sout == 3'h0; k++) tick();
    chk(sout, exp);
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  // a hang counts as a mismatch, the run needs well under a thousand cycles
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      fail_count++;
      end_sim();
    end
  end
  initial begin
    {ireq, dreq, dst, dz, inv, inva, sx, sh, ss, si, sst, sp} = 12'h000;
    {iea, dea, iv_ea, sea} = 128'h0;
    slow = 4'h0;
    ce = 1'b1;
    rst = 1'b1;
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  initial begin
    tick(3);
    rst = 1'b0;
    chk({attr, glob, excl}, 5'h06);
    for (int s = 0; s < 32; s++) inval(s[4:0]);
    ilook(ea(5, 6'h2A), 2'b01);
    dlook(ea(5, 6'h2A), 1'b0, 1'b0, 4'b0100);
    dlook(ea(5, 6'h2A), 1'b0, 1'b1, 4'b0010);
    inva = 1'b1;
    tick();
    inva = 1'b0;
    chk({ill, iout, dout}, 7'h40);
    // hold high: stall until hold drops, then done
    sh = 1'b1;
    sx = 1'b1;
    tick();
    sx = 1'b0;
    for (int k = 0; k < 4; k++) begin
      chk({stall, sdone}, 2'b10);
      tick();
    end
    sh = 1'b0;
    for (int k = 0; k < 3 && sdone !== 1'b1; k++) tick();
    chk({stall, sdone}, 2'b01);
    sx = 1'b1;
    tick();
    sx = 1'b0;
    chk({stall, sdone}, 2'b01);
    // primary hit after seven near misses, load sets only the referenced bit
    fill(6'h2A);
    mem.pte[1] = mk(1'b0, 1'b0, VS, 6'h2A, 1'b0, 1'b0, 1'b0);
    mem.pte[2] = mk(1'b1, 1'b0, VS ^ 24'h1, 6'h2A, 1'b0, 1'b0, 1'b0);
    mem.pte[3] = mk(1'b1, 1'b0, VS, 6'h15, 1'b0, 1'b0, 1'b0);
    mem.pte[7] = mk(1'b1, 1'b0, VS, 6'h2A, 1'b0, 1'b0, 1'b0);
    srch(1'b0, 1'b0, 1'b0, ea(5, 6'h2A), 3'b100);
    chk({mem.pte[7][8:7], 8'(mem.n_wr - w0)}, 10'h201);
    dlook(ea(5, 6'h2A), 1'b0, 1'b0, 4'b1000);
    dlook(ea(5, 6'h2A), 1'b1, 1'b0, 4'b0010);
    ilook(ea(5, 6'h2A), 2'b01);
    // secondary hit with slow memory, store writes only the changed bit
    slow = 4'h3;
    fill(6'h15);
    mem.pte[11] = mk(1'b1, 1'b1, VS, 6'h15, 1'b1, 1'b0, 1'b0);
    srch(1'b0, 1'b1, 1'b0, ea(5, 6'h15), 3'b100);
    chk({mem.pte[11][8:7], 8'(mem.n_wr - w0)}, 10'h301);
    slow = 4'h0;
    dlook(ea(5, 6'h15), 1'b1, 1'b0, 4'b1000);
    dlook(ea(5, 6'h2A), 1'b0, 1'b0, 4'b1000);
    // a frozen clock enable must swallow the invalidate
    ce = 1'b0;
    inval(5'd5);
    ce = 1'b1;
    dlook(ea(5, 6'h2A), 1'b0, 1'b0, 4'b1000);
    // protection violation: referenced bit only; write-through page refuses zeroing
    fill(6'h0C);
    mem.pte[0] = mk(1'b1, 1'b0, VS, 6'h0C, 1'b0, 1'b0, 1'b1);
    srch(1'b0, 1'b1, 1'b1, ea(12, 6'h0C), 3'b100);
    chk({mem.pte[0][8:7], 8'(mem.n_wr - w0)}, 10'h201);
    dlook(ea(12, 6'h0C), 1'b0, 1'b1, 4'b0001);
    fill(6'h31);
    mem.pte[5] = mk(1'b1, 1'b0, VS, 6'h31, 1'b1, 1'b1, 1'b0);
    srch(1'b1, 1'b0, 1'b0, ea(9, 6'h31), 3'b100);
    chk(mem.n_wr - w0, 0);
    ilook(ea(9, 6'h31), 2'b10);
    fill(6'h22);
    srch(1'b1, 1'b0, 1'b0, ea(20, 6'h22), 3'b010);
    srch(1'b0, 1'b0, 1'b0, ea(20, 6'h22), 3'b001);
    inval(5'd5);
    dlook(ea(5, 6'h2A), 1'b0, 1'b0, 4'b0100);
    dlook(ea(5, 6'h15), 1'b0, 1'b0, 4'b0100);
    dlook(ea(12, 6'h0C), 1'b0, 1'b0, 4'b1000);
    // invalidate in the lookup cycle hides the set at once
    iv_ea = ea(12, 6'h0C);
    inv = 1'b1;
    dlook(ea(12, 6'h0C), 1'b0, 1'b0, 4'b0100);
    inval(5'd9);
    ilook(ea(9, 6'h31), 2'b01);
    end_sim();
  end
endmodule
